// ===== include/srm_pkg.sv
// Shared constants for the spread and randomize modulator
package srm_pkg;

  // Channel counts
  localparam int NCH = 4; // Configurable data channels besides the common pilot

  // Clock and chip timing
  localparam int CLK_KHZ = 10000; // System clock rate in kHz
  localparam int CHIP_KHZ_LO = 1920; // Lower chip rate option in kchip/s
  localparam int CHIP_KHZ_HI = 3840; // Higher chip rate option in kchip/s
  localparam logic [2:0] CHIP_DIV_LO = 3'(CLK_KHZ / CHIP_KHZ_LO); // Clocks per chip, rounded down
  localparam logic [2:0] CHIP_DIV_HI = 3'(CLK_KHZ / CHIP_KHZ_HI); // Clocks per chip, rounded down
  localparam logic [3:0] SF_LOG_MAX_LO = 4'h7; // Code length 128 at lower chip rate
  localparam logic [3:0] SF_LOG_MAX_HI = 4'h8; // Code length 256 at higher chip rate
  localparam logic [3:0] SF_LOG_RST = 4'h5; // Reference spreading factor 32

  // Pilot spacing: one pilot dibit per this many symbols
  localparam logic [3:0] PILOT_SPACING = 4'ha;
  localparam logic [1:0] PILOT_DIBIT = 2'h0; // Maps to +1 on both branches

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CODE_I = 8'h04;
  localparam logic [7:0] OFS_CODE_Q = 8'h08;
  localparam logic [7:0] OFS_FOFS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control field positions
  localparam int CB_EN = 0;
  localparam int CB_RET = 1;
  localparam int CB_HI = 2;
  localparam int CB_SF = 3; // 4 bits, log2 of spreading factor
  localparam int CB_DUAL = 7;
  localparam int CB_SHARED = 8;
  localparam int CB_RAND = 9; // 2 bits
  localparam int CB_PI4 = 11;
  localparam int CB_FM = 12;
  localparam int CB_PILOT = 16; // NCH bits
  localparam logic [31:0] CTRL_RST = 32'h0000_0828; // SF 32, pi/4 on

  // Randomization modes
  typedef enum logic [1:0] {RAND_REAL, RAND_CPLX, RAND_IQ} srm_rand_t;

  // Randomization code generators: specific I, specific Q, common
  localparam int PN_W = 18;
  localparam logic [PN_W-1:0] PN_SEED [3] = '{18'h00001, 18'h1ffff, 18'h15555};
  localparam logic [PN_W-1:0] PN_TAPS [3] = '{18'h20400, 18'h204a0, 18'h20041};

endpackage

// ===== include/srm_pn_if.sv
// Link between the modulator core and its randomization code generators
`timescale 1ns/100ps
interface srm_pn_if;
  logic step; // Advance all generators by one chip
  logic restart; // Reload seeds at the frame reference chip
  logic [2:0] code; // Current chip of each generator
  modport gen (input step, input restart, output code);
  modport user (output step, output restart, input code);
endinterface

// ===== verification/srm_monitor.sv
// Checker for the modulator's bus answers and chip stream
`timescale 1ns/100ps
module srm_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Chip stream
  input wire logic [srm_pkg::NCH-1:0] ch_take_o,
  input wire logic signed [5:0] chip_i_o,
  input wire logic signed [5:0] chip_q_o,
  input wire logic chip_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////
  // Request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Acknowledge lasts exactly one cycle
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_next;
    s_req |=> s_ack;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  // Reads at offsets 0x14 and above answer zero
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h14 |-> wb_dat_o == 32'h0;
  endproperty

  ////////////////////////////////////////////////////////////////
  // One strobe per chip, values held in between
  property p_valid_pulse;
    chip_valid_o |=> !chip_valid_o;
  endproperty
  property p_chip_hold;
    !chip_valid_o |-> $stable(chip_i_o) && $stable(chip_q_o);
  endproperty
  // A consumed symbol goes out with a chip
  property p_take_chip;
    |ch_take_o |-> ##[0:1] chip_valid_o;
  endproperty
  property p_take_pulse;
    |ch_take_o |=> ch_take_o == '0;
  endproperty
  // Channel sum plus pilot, complex product at most doubles it
  property p_chip_range;
    chip_valid_o |-> chip_i_o <= 6'sd10 && chip_i_o >= -6'sd10 && chip_q_o <= 6'sd10 && chip_q_o >= -6'sd10;
  endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack missing or too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_valid_pulse: assert property (p_valid_pulse) else $error("chip strobe too long");
  a_chip_hold: assert property (p_chip_hold) else $error("chip changed off strobe");
  a_take_chip: assert property (p_take_chip) else $error("take without chip");
  a_take_pulse: assert property (p_take_pulse) else $error("take too long");
  a_chip_range: assert property (p_chip_range) else $error("chip out of range");
endmodule

bind srm_top srm_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .ch_take_o, .chip_i_o, .chip_q_o, .chip_valid_o);

// ===== verification/srm_sink.sv
// Chip sink standing in for the pulse-shaping filter
`timescale 1ns/100ps
module srm_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Chip stream
  input wire logic signed [5:0] chip_i_i,
  input wire logic signed [5:0] chip_q_i,
  input wire logic chip_valid_i,
  // Observation
  output int chip_count_o,
  output logic signed [5:0] last_i_o
);
  // Filter never stalls, so every strobe is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chip_count_o <= 0;
    else if (chip_valid_i)
      chip_count_o <= chip_count_o + 1;
  end
  // Last I sample, Q kept only for symmetry of the port list
  always_ff @(posedge clk_i)
  begin
    if (chip_valid_i)
      last_i_o <= chip_i_i + (chip_q_i & 6'sd0);
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the spread and randomize modulator
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, frame_ref_i = 1'b0, sync_burst_i = 1'b0, chip_valid_o, rot_phase_o, precomp_const_env_fm_o, r;
  logic [2*srm_pkg::NCH-1:0] ch_dibit_i = '0;
  logic [srm_pkg::NCH-1:0] ch_take_o;
  logic signed [5:0] chip_i_o, chip_q_o, last_i;
  int failures = 0, check_count = 0, cycles = 0, chip_count, n0;
  logic [31:0] rnd = 32'hca8fec4e;
  logic [63:0] exp_q [$]; // Expected reads: mask then value
  logic [63:0] e;
  // Take spacing table: control, symbol clocks, chip clocks
  int cf [4] = '{32'h28, 32'h48, 32'h4c, 32'h2c};
  int ct [4] = '{160, 640, 512, 64};
  int cc [4] = '{5, 5, 2, 2};
  // Randomization table: control, effective mode, sync burst
  int mc [6] = '{32'h200, 32'h580, 32'h1002, 32'h402, 32'h282, 32'h580};
  int me [6] = '{0, 2, 1, 2, 1, 0};
  int ms [6] = '{0, 0, 0, 0, 0, 1};

  srm_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .frame_ref_i, .sync_burst_i, .ch_dibit_i, .ch_take_o, .chip_i_o, .chip_q_o, .chip_valid_o,
    .rot_phase_o, .precomp_const_env_fm_o);
  srm_sink u_sink (.clk_i, .rst_i, .chip_i_i(chip_i_o), .chip_q_i(chip_q_o), .chip_valid_i(chip_valid_o),
    .chip_count_o(chip_count), .last_i_o(last_i));

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Fresh random dibits once the current ones are consumed
  always @(posedge clk_i)
  begin
    rnd <= lfsr(rnd);
    if (|ch_take_o)
      ch_dibit_i <= rnd[7:0];
  end
  // Hang guard, well beyond the longest sequence
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      give_verdict();
    end
  end
  // Each read answer against the oldest note
  always @(posedge clk_i)
  begin
    if (wb_ack_o && !wb_we_i)
    begin
      e = exp_q.pop_front();
      `CHK(wb_dat_o & e[63:32], e[31:0])
    end
  end

  ////////////////////////////////////////////////////////////////
  // One classic cycle, held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i iff wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
    wb(1'b0, a, 32'h0);
  endtask
  // Spacing of symbol takes and of chip strobes
  task automatic gap(input int et, input int ec);
    int t1;
    @(posedge clk_i iff ch_take_o[0]);
    t1 = cycles;
    @(posedge clk_i iff ch_take_o[0]);
    `CHK(cycles - t1, et)
    @(posedge clk_i iff chip_valid_o);
    t1 = cycles;
    @(posedge clk_i iff chip_valid_o);
    `CHK(cycles - t1, ec)
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(srm_pkg::OFS_CTRL, 32'hffffffff, srm_pkg::CTRL_RST);
    rd(8'h20, 32'hffffffff, 32'h0);
    rd(srm_pkg::OFS_CODE_I, 32'hffffffff, 32'h0);
    // Pilot alone: both branches carry the bare code
    wb(1'b1, srm_pkg::OFS_CTRL, srm_pkg::CTRL_RST | 32'h1);
    frame_ref_i <= 1'b1;
    @(posedge clk_i);
    frame_ref_i <= 1'b0;
    // Restart lands on the first chip, so the seed chip is sent twice
    repeat (2)
    begin
      @(posedge clk_i iff chip_valid_o);
      `CHK(chip_i_o, srm_pkg::PN_SEED[0][0] ? -6'sd1 : 6'sd1)
    end
    repeat (6)
    begin
      @(posedge clk_i iff chip_valid_o);
      `CHK(chip_i_o, chip_q_o)
      `CHK(chip_i_o * chip_i_o, 6'sd1)
    end
    sync_burst_i <= 1'b1;
    repeat (2) @(posedge clk_i iff chip_valid_o);
    `CHK({chip_i_o, chip_q_o}, 12'h0)
    `CHK(last_i, 6'sd0)
    sync_burst_i <= 1'b0;
    // Frozen settings: code write dropped, only enable changes
    wb(1'b1, srm_pkg::OFS_CODE_I, 32'h55);
    rd(srm_pkg::OFS_CODE_I, 32'hffffffff, 32'h0);
    wb(1'b1, srm_pkg::OFS_CTRL, 32'h0);
    rd(srm_pkg::OFS_CTRL, 32'hffffffff, srm_pkg::CTRL_RST);
    n0 = chip_count;
    repeat (20) @(posedge clk_i);
    `CHK(chip_count, n0)
    wb(1'b1, srm_pkg::OFS_CODE_I, 32'h1);
    wb(1'b1, srm_pkg::OFS_CODE_Q, 32'h1);
    rd(srm_pkg::OFS_CODE_Q, 32'hffffffff, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, srm_pkg::OFS_CTRL, 32'h801 | cf[k]);
      gap(ct[k], cc[k]);
      wb(1'b1, srm_pkg::OFS_CTRL, 32'h0);
    end
    // Pilot every tenth symbol on channel 0: that symbol takes no dibit
    wb(1'b1, srm_pkg::OFS_CTRL, 32'h1082d);
    repeat (9) @(posedge clk_i iff ch_take_o[0]);
    n0 = cycles;
    @(posedge clk_i iff ch_take_o[0]);
    `CHK(cycles - n0, 128)
    wb(1'b1, srm_pkg::OFS_CTRL, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      sync_burst_i <= ms[k][0];
      wb(1'b1, srm_pkg::OFS_CTRL, 32'h829 | mc[k]);
      rd(srm_pkg::OFS_STATUS, 32'h6, 32'(me[k] << 1));
      `CHK(precomp_const_env_fm_o, mc[k][1] & mc[k][12])
      if (mc[k][1])
      begin
        @(posedge clk_i iff chip_valid_o);
        r = rot_phase_o;
        @(posedge clk_i iff chip_valid_o);
        `CHK(rot_phase_o, !r)
      end
      wb(1'b1, srm_pkg::OFS_CTRL, 32'h0);
    end
    give_verdict();
  end
endmodule

// ===== verilog/srm_pn_gen.sv
// Randomization code generators, one LFSR per code
`timescale 1ns/100ps
module srm_pn_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  srm_pn_if.gen pn
);

  ////////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_lfsr
      logic [srm_pkg::PN_W-1:0] lfsr_reg; // Galois register
      // Free running on chip steps; only reset and the frame reference restart reload it
      always_ff @(posedge clk_i)
      begin
        if (rst_i || pn.restart)
        begin
          lfsr_reg <= srm_pkg::PN_SEED[g];
        end
        else if (pn.step)
        begin
          lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ srm_pkg::PN_TAPS[g]) : (lfsr_reg >> 1);
        end
      end
      assign pn.code[g] = lfsr_reg[0];
    end
  endgenerate

endmodule

// ===== verilog/srm_top.sv
// Spread and randomize modulator core with Wishbone register access
//
// How it works
// - Pilot dibits multiplexed in before I/Q split
// - Each dibit splits into I and Q bipolar
// - Branch sample held per symbol times code
// - Spread chips multiplied by PN randomization chips
// - Real mode: one code on both branches
// - Complex mode: full complex multiply, two codes
// - I/Q mode: separate codes, no cross terms
// - Four-phase same code; dual binary two codes
// - Code length 128 at 1.920 Mchip/s; the divider of 5 at 10000 kHz gives 2000 kchip/s
// - Code length 256 at 3.840 Mchip/s; the divider of 2 at 10000 kHz gives 5000 kchip/s
// - Forward channels summed before randomization
// - Forward traffic uses real randomization
// - Optional shared-code dual binary, I/Q randomization
// - Sync burst sent with real randomization
// - Common pilot uses all-ones code zero
// - Pilot symbols ones, muted during sync burst
// - Return dedicated uses complex randomization
// - Random access burst uses complex randomization
// - Return uses pi/4 shift, optional FM
// - Reference spreading factor is 32 chips
// - Fixed configurable frame offset in chips
// - Code restarts at frame reference chip
// - Code generator keeps running through interruptions
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module srm_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System timing
  input wire logic frame_ref_i,
  input wire logic sync_burst_i,
  // Channel symbol sources
  input wire logic [2*srm_pkg::NCH-1:0] ch_dibit_i,
  output logic [srm_pkg::NCH-1:0] ch_take_o,
  // Chip stream to pulse shaping
  output logic signed [5:0] chip_i_o,
  output logic signed [5:0] chip_q_o,
  output logic chip_valid_o,
  output logic rot_phase_o,
  output logic precomp_const_env_fm_o
);

  localparam int NCH = srm_pkg::NCH;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_reg; // Session configuration and enable
  logic [31:0] code_i_reg; // I-branch code index, one byte per channel
  logic [31:0] code_q_reg; // Q-branch code index, one byte per channel
  logic [7:0] fofs_reg; // Frame offset in chips
  logic [31:0] rd_data; // Read mux output
  logic wb_req; // Live request not yet acknowledged
  logic wb_wr; // Write strobe at acknowledge
  logic enable; // Session running
  logic [31:0] wmask; // Byte-lane mask from sel

  assign enable = ctrl_reg[srm_pkg::CB_EN];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Acknowledge every request one cycle after it appears, mapped or not
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_data;
    end
  end

  // Control register; only the enable bit moves while a session runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= srm_pkg::CTRL_RST;
    end
    else if (wb_wr && wb_adr_i == srm_pkg::OFS_CTRL)
    begin
      if (enable)
      begin
        // Frozen fields keep the running session consistent
        if (wb_sel_i[0])
        begin
          ctrl_reg[srm_pkg::CB_EN] <= wb_dat_i[srm_pkg::CB_EN];
        end
      end
      else
      begin
        ctrl_reg <= (ctrl_reg & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  // Code indices and frame offset, writable only when idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code_i_reg <= 32'h0000_0000;
      code_q_reg <= 32'h0000_0000;
      fofs_reg <= 8'h00;
    end
    else if (wb_wr && !enable)
    begin
      if (wb_adr_i == srm_pkg::OFS_CODE_I)
      begin
        code_i_reg <= (code_i_reg & ~wmask) | (wb_dat_i & wmask);
      end
      if (wb_adr_i == srm_pkg::OFS_CODE_Q)
      begin
        code_q_reg <= (code_q_reg & ~wmask) | (wb_dat_i & wmask);
      end
      if (wb_adr_i == srm_pkg::OFS_FOFS && wb_sel_i[0])
      begin
        fofs_reg <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Derived configuration
  logic link_ret; // Return link when set
  logic chip_hi; // Higher chip rate option
  logic [3:0] sf_log_req; // Requested log2 spreading factor
  logic [3:0] sf_log; // Clamped log2 spreading factor
  logic [7:0] sf_m1; // Spreading factor minus one
  logic [2:0] chip_div; // Clocks per chip
  logic mod_dual; // Dual binary modulation
  logic shared_code; // Dual binary on one shared code
  srm_pkg::srm_rand_t rand_req; // Mode asked for by software
  srm_pkg::srm_rand_t rand_eff; // Mode actually applied

  assign link_ret = ctrl_reg[srm_pkg::CB_RET];
  assign chip_hi = ctrl_reg[srm_pkg::CB_HI];
  assign sf_log_req = ctrl_reg[srm_pkg::CB_SF +: 4];
  assign mod_dual = ctrl_reg[srm_pkg::CB_DUAL];
  assign shared_code = ctrl_reg[srm_pkg::CB_SHARED];
  assign rand_req = srm_pkg::srm_rand_t'(ctrl_reg[srm_pkg::CB_RAND +: 2]);
  assign chip_div = chip_hi ? srm_pkg::CHIP_DIV_HI : srm_pkg::CHIP_DIV_LO;

  // Code length limit follows the chip rate option; reset value gives 32
  always_comb
  begin
    if (chip_hi && sf_log_req > srm_pkg::SF_LOG_MAX_HI)
    begin
      sf_log = srm_pkg::SF_LOG_MAX_HI;
    end
    else if (!chip_hi && sf_log_req > srm_pkg::SF_LOG_MAX_LO)
    begin
      sf_log = srm_pkg::SF_LOG_MAX_LO;
    end
    else
    begin
      sf_log = sf_log_req;
    end
    sf_m1 = 8'((9'h001 << sf_log) - 9'h001);
  end

  // Randomization mode chosen from link direction and channel type
  always_comb
  begin
    if (!link_ret && sync_burst_i)
    begin
      rand_eff = srm_pkg::RAND_REAL;
    end
    else if (!link_ret)
    begin
      // Forward: real, unless I/Q is asked for with shared-code dual binary set
      rand_eff = (rand_req == srm_pkg::RAND_IQ && mod_dual && shared_code) ?
                 srm_pkg::RAND_IQ : srm_pkg::RAND_REAL;
    end
    else
    begin
      // Return: complex, or I/Q independent when code-book size matters
      rand_eff = (rand_req == srm_pkg::RAND_IQ) ? srm_pkg::RAND_IQ : srm_pkg::RAND_CPLX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chip timing
  logic [2:0] div_reg; // Clock divider toward chip rate
  logic chip_stb; // One clock per chip
  logic [7:0] chip_cnt_reg; // Chip position within the symbol
  logic sym_stb; // Last chip of a symbol
  logic [15:0] sym_cnt_reg; // Symbols sent, status only

  assign chip_stb = enable && (div_reg == chip_div - 3'h1);
  assign sym_stb = chip_stb && (chip_cnt_reg == sf_m1);

  // Chip divider; chips only run in a session
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable || chip_stb)
    begin
      div_reg <= 3'h0;
    end
    else
    begin
      div_reg <= div_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame reference with fixed offset
  typedef enum logic {FR_IDLE, FR_WAIT} srm_fr_t;
  srm_fr_t fr_state_reg; // Offset wait state
  logic [7:0] fr_cnt_reg; // Chips left before restart
  logic restart; // Realign code and symbol to the frame

  assign restart = (fr_state_reg == FR_WAIT) && chip_stb && (fr_cnt_reg == 8'h00);

  // Wait the programmed number of chips after the frame reference
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
    begin
      fr_state_reg <= FR_IDLE;
      fr_cnt_reg <= 8'h00;
    end
    else
    begin
      case (fr_state_reg)
        FR_IDLE:
        begin
          if (frame_ref_i)
          begin
            fr_state_reg <= FR_WAIT;
            fr_cnt_reg <= fofs_reg;
          end
        end
        FR_WAIT:
        begin
          if (restart)
          begin
            fr_state_reg <= FR_IDLE;
          end
          else if (chip_stb)
          begin
            fr_cnt_reg <= fr_cnt_reg - 8'h01;
          end
        end
        default:
        begin
          fr_state_reg <= FR_IDLE;
        end
      endcase
    end
  end

  // Chip and symbol counters; restart loads chip one for the chip after the frame chip
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
    begin
      chip_cnt_reg <= 8'h00;
      sym_cnt_reg <= 16'h0000;
    end
    else if (restart)
    begin
      chip_cnt_reg <= 8'h01;
    end
    else if (sym_stb)
    begin
      chip_cnt_reg <= 8'h00;
      sym_cnt_reg <= sym_cnt_reg + 16'h0001;
    end
    else if (chip_stb)
    begin
      chip_cnt_reg <= chip_cnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Randomization code generators
  srm_pn_if pn_if ();

  // Steps on every chip, sync bursts and gaps included
  assign pn_if.step = chip_stb;
  assign pn_if.restart = restart;

  srm_pn_gen u_pn (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pn (pn_if.gen)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel pilot insertion, split and spreading
  logic [NCH-1:0] spread_i; // Spread I chip per channel, 1 means -1
  logic [NCH-1:0] spread_q; // Spread Q chip per channel
  logic [NCH-1:0] ch_on; // Channel carries data or pilot

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : gen_ch
      logic [1:0] dibit_reg; // Symbol held across the whole code vector
      logic [3:0] pil_cnt_reg; // Position in the pilot spacing
      logic pilot_slot; // Next symbol is a pilot
      logic [7:0] idx_i; // I code index
      logic [7:0] idx_q; // Q code index
      logic pil_en; // Pilots required on this channel

      assign pil_en = ctrl_reg[srm_pkg::CB_PILOT + c];
      assign pilot_slot = pil_en && (pil_cnt_reg == 4'h0);
      assign ch_on[c] = (code_i_reg[8*c +: 8] != 8'h00) || (code_q_reg[8*c +: 8] != 8'h00);
      // Source gives a dibit at each symbol that is not a pilot
      assign ch_take_o[c] = sym_stb && ch_on[c] && !pilot_slot;

      // Load the next symbol: pilot or user dibit
      always_ff @(posedge clk_i)
      begin
        if (rst_i || !enable)
        begin
          dibit_reg <= srm_pkg::PILOT_DIBIT;
          pil_cnt_reg <= 4'h0;
        end
        else if (sym_stb)
        begin
          dibit_reg <= pilot_slot ? srm_pkg::PILOT_DIBIT : ch_dibit_i[2*c +: 2];
          pil_cnt_reg <= (pil_cnt_reg == srm_pkg::PILOT_SPACING - 4'h1) ? 4'h0 : pil_cnt_reg + 4'h1;
        end
      end

      // Four-phase and shared-code dual binary reuse the I code on Q
      assign idx_i = code_i_reg[8*c +: 8] & sf_m1;
      assign idx_q = ((mod_dual && !shared_code) ? code_q_reg[8*c +: 8] : code_i_reg[8*c +: 8]) & sf_m1;

      // Bipolar product is an XOR of sign bits; Walsh chip is a parity
      assign spread_i[c] = dibit_reg[1] ^ (^(idx_i & chip_cnt_reg));
      assign spread_q[c] = dibit_reg[0] ^ (^(idx_q & chip_cnt_reg));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Branch sums, pilot channel included
  logic signed [3:0] sum_i; // Sum of I chips before randomization
  logic signed [3:0] sum_q; // Sum of Q chips before randomization
  logic pilot_on; // Common pilot present on forward link

  // Pilot: all-ones symbols on code zero, so its chips are the code itself
  assign pilot_on = !link_ret && !sync_burst_i;

  // Add every channel with a nonzero code index per branch; one randomization then covers them all
  always_comb
  begin
    sum_i = pilot_on ? 4'sd1 : 4'sd0;
    sum_q = pilot_on ? 4'sd1 : 4'sd0;
    for (int k = 0; k < NCH; k++)
    begin
      if (ch_on[k])
      begin
        sum_i = sum_i + (spread_i[k] ? -4'sd1 : 4'sd1);
        sum_q = sum_q + (spread_q[k] ? -4'sd1 : 4'sd1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Randomization
  logic signed [5:0] si; // Sign-extended I sum
  logic signed [5:0] sq; // Sign-extended Q sum
  logic signed [5:0] ri; // I times first code
  logic signed [5:0] rq; // Q times first code
  logic signed [5:0] xi; // I times second code
  logic signed [5:0] xq; // Q times second code
  logic cr1; // First randomization chip, 1 means -1
  logic cr2; // Second randomization chip
  logic signed [5:0] out_i; // Randomized I chip
  logic signed [5:0] out_q; // Randomized Q chip

  // Sync bursts take the common code, everything else the specific pair
  assign cr1 = (!link_ret && sync_burst_i) ? pn_if.code[2] : pn_if.code[0];
  assign cr2 = pn_if.code[1];
  assign si = 6'(sum_i);
  assign sq = 6'(sum_q);
  assign ri = cr1 ? -si : si;
  assign rq = cr1 ? -sq : sq;
  assign xi = cr2 ? -si : si;
  assign xq = cr2 ? -sq : sq;

  // Mode select; complex form is (I + jQ)(c1 + jc2)
  always_comb
  begin
    case (rand_eff)
      srm_pkg::RAND_REAL:
      begin
        out_i = ri;
        out_q = rq;
      end
      srm_pkg::RAND_CPLX:
      begin
        out_i = ri - xq;
        out_q = xi + rq;
      end
      srm_pkg::RAND_IQ:
      begin
        out_i = ri;
        out_q = xq;
      end
      default:
      begin
        out_i = ri;
        out_q = rq;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chip output toward the shaping filter
  // Registered so downstream sees stable chips between strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chip_i_o <= 6'sd0;
      chip_q_o <= 6'sd0;
      chip_valid_o <= 1'b0;
    end
    else
    begin
      chip_valid_o <= chip_stb;
      if (chip_stb)
      begin
        chip_i_o <= out_i;
        chip_q_o <= out_q;
      end
    end
  end

  // Return-link pi/4 phase step per chip; FM option is passed on
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
    begin
      rot_phase_o <= 1'b0;
      precomp_const_env_fm_o <= 1'b0;
    end
    else
    begin
      precomp_const_env_fm_o <= link_ret && ctrl_reg[srm_pkg::CB_FM];
      if (chip_stb && link_ret && ctrl_reg[srm_pkg::CB_PI4])
      begin
        rot_phase_o <= !rot_phase_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped offsets read zero
  always_comb
  begin
    case (wb_adr_i)
      srm_pkg::OFS_CTRL: rd_data = ctrl_reg;
      srm_pkg::OFS_CODE_I: rd_data = code_i_reg;
      srm_pkg::OFS_CODE_Q: rd_data = code_q_reg;
      srm_pkg::OFS_FOFS: rd_data = {24'h000000, fofs_reg};
      srm_pkg::OFS_STATUS: rd_data = {sym_cnt_reg, chip_cnt_reg, 3'h0, sync_burst_i,
                                      fr_state_reg == FR_WAIT, rand_eff, enable};
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule
